// >>> rtl/ssic_lane.sv
// One byte lane of the storage array: eight data bits and a parity bit.
// Assumes write enable and index come from the control pipeline on CLOCK.
`timescale 1ns/1ns
module ssic_lane
    import ssic_pkg::*;
(
    input  wire logic                  clk,      // System clock
    input  wire logic                  wr,       // Write this lane this cycle
    input  wire logic [ADDR_W-1:0]     wr_index, // Write location
    input  wire logic [LANE_W-1:0]     wr_data,  // Data byte plus parity
    input  wire logic [ADDR_W-1:0]     rd_index, // Read location
    output logic      [LANE_W-1:0]     rd_data   // Raw array read
);
    // ==================================================
    // Storage
    logic [LANE_W-1:0] mem [DEPTH];               // Lane array, no reset needed

    // Array write, one byte with its parity bit
    always_ff @(posedge clk)
    begin
        if (wr)
        begin
            mem[wr_index] <= wr_data;
        end
    end

    // Combinational read; the top registers the output
    assign rd_data = mem[rd_index];
endmodule // ssic_lane

// >>> rtl/ssic_pkg.sv
// Package for the synchronous SRAM input control block.
// Assumes one clock domain; all widths fixed here.
package ssic_pkg;
    // ==================================================
    // Widths
    localparam int ADDR_W   = 6;                  // Word address width
    localparam int LANES    = 4;                  // Byte lanes a..d
    localparam int LANE_W   = 9;                  // Eight data bits plus parity
    localparam int DATA_W   = 8;                  // Data bits per lane
    localparam int DEPTH    = 64;                 // Words held in flip-flops
    localparam int BURST_W  = 2;                  // Burst counter width
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    localparam logic [LANES-1:0]   LANES_OFF  = 4'hf; // All byte selects inactive
    // Access kind held through the pipeline
    typedef enum logic [1:0] {SSIC_IDLE, SSIC_READ, SSIC_WRITE} ssic_op_t;
endpackage

// >>> rtl/ssic_top.sv
// Input control of a pipelined burst SRAM: pin sampling, write, burst, select.
// Assumes pins are driven synchronously to CLOCK by a controller (no sync stage).
`timescale 1ns/1ns
module ssic_top
    import ssic_pkg::*;
(
    input  wire logic                      CLOCK,            // 100 MHz clock
    input  wire logic                      SYS_RST,          // Sync reset, high
    input  wire logic [ADDR_W-1:0]         ADDR,             // Address incl. addr_bit1/0
    input  wire logic [LANES-1:0]          BYTE_LANE_WRITE_N,// Lane selects, low
    input  wire logic                      WRITE_N,          // Write strobe, low
    input  wire logic                      ADVANCE_OR_LOAD,  // 1 advance, 0 load
    input  wire logic                      CLOCK_QUALIFY_N,  // Clock enable, low
    input  wire logic                      CHIP_SELECT_1_N,  // Select, low
    input  wire logic                      CHIP_SELECT_2,    // Select, high
    input  wire logic                      CHIP_SELECT_3_N,  // Select, low
    input  wire logic                      BURST_INTERLEAVE, // Strap: 1 interleaved
    input  wire logic                      OUTPUT_ENABLE_N,  // Async output enable
    input  wire logic [LANES*LANE_W-1:0]   DATA_IN,          // Data and parity_io in
    output logic      [LANES*LANE_W-1:0]   DATA_OUT,         // Registered read data
    output logic      [LANES*LANE_W-1:0]   DATA_OE           // High while driving
);
    // ==================================================
    // State record
    typedef struct packed {
        logic [ADDR_W-1:0]  base;       // Loaded start address
        logic [BURST_W-1:0] count;      // Burst step count
        ssic_op_t           op1;        // Access taken last edge
        logic [ADDR_W-1:0]  addr1;      // Its address
        logic [LANES-1:0]   lanes1;     // Its lane selects
        ssic_op_t           op2;        // Access in data phase
        logic               was_desel;  // Previous access was a deselect
        logic               first;      // First cycle after leaving deselect
        logic               strap;      // Burst order caught while reset is held
        logic [LANES*LANE_W-1:0] dout;  // Output register
    } ssic_state_t;

    ssic_state_t st;                     // Current state
    ssic_state_t next_st;                // Next state
    logic        selected;               // All three selects active
    logic        adv_ok;                 // Advance allowed (a burst is open)
    logic [ADDR_W-1:0]  burst_addr;      // Address after this advance
    logic [BURST_W-1:0] next_count;      // Advanced count
    logic [BURST_W-1:0] low_bits;        // Burst low address bits
    logic [LANES-1:0]   lane_wr;         // Per-lane array write
    logic [LANES*LANE_W-1:0] rd_word;    // Array read word
    logic        drive;                  // Output drivers on

    // ==================================================
    // Selection and burst address
    assign selected = !CHIP_SELECT_1_N && CHIP_SELECT_2 && !CHIP_SELECT_3_N;
    assign adv_ok   = (st.op1 != SSIC_IDLE);
    assign next_count = st.count + BURST_ONE;

    // Interleaved order XORs the count in, linear order adds it
    always_comb
    begin
        if (st.strap)
        begin
            low_bits = st.base[BURST_W-1:0] ^ next_count;
        end
        else
        begin
            low_bits = st.base[BURST_W-1:0] + next_count;
        end
        burst_addr = {st.base[ADDR_W-1:BURST_W], low_bits};
    end

    // ==================================================
    // Next state: reset acts on any edge; every other update is held unless the edge is qualified
    always_comb
    begin
        next_st = st;
        if (SYS_RST)
        begin
            next_st = '0;
            next_st.op1 = SSIC_IDLE;
            next_st.op2 = SSIC_IDLE;
            next_st.was_desel = 1'b1;
            next_st.strap = BURST_INTERLEAVE;                  // strap caught at reset
        end
        else if (!CLOCK_QUALIFY_N)
        begin
            next_st.op2 = st.op1;
            next_st.dout = rd_word;
            next_st.first = 1'b0;
            if (ADVANCE_OR_LOAD)
            begin
                // Advance continues the previous access kind; after a
                // deselect there is nothing to advance, so it idles.
                if (adv_ok)
                begin
                    next_st.count = next_count;
                    next_st.addr1 = burst_addr;
                    next_st.lanes1 = BYTE_LANE_WRITE_N;
                end
                else
                begin
                    next_st.op1 = SSIC_IDLE;
                end
            end
            else if (selected)
            begin
                next_st.base  = ADDR;
                next_st.addr1 = ADDR;
                next_st.count = BURST_ZERO;
                next_st.lanes1 = BYTE_LANE_WRITE_N;
                next_st.op1 = WRITE_N ? SSIC_READ : SSIC_WRITE;
                next_st.first = st.was_desel;
                next_st.was_desel = 1'b0;
            end
            else
            begin
                next_st.op1 = SSIC_IDLE;
                next_st.was_desel = 1'b1;
            end
        end
    end

    // Single register of the whole state, CLOCK only
    always_ff @(posedge CLOCK)
    begin
        st <= next_st;
    end

    // ==================================================
    // Array lanes: write lands on the next qualified edge after the command, with its data
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign lane_wr[g] = !CLOCK_QUALIFY_N && !SYS_RST && (st.op1 == SSIC_WRITE)
                                && !st.lanes1[g];
            ssic_lane u_lane (
                .clk      (CLOCK),
                .wr       (lane_wr[g]),
                .wr_index (st.addr1),
                .wr_data  (DATA_IN[g*LANE_W +: LANE_W]),
                .rd_index (st.addr1),
                .rd_data  (rd_word[g*LANE_W +: LANE_W])
            );
        end
    endgenerate

    // ==================================================
    // Output drivers: only for a read data phase, the first read after a deselect included
    // The enable pin can only hold the drivers off, never turn them on alone
    assign drive    = (st.op2 == SSIC_READ) && !st.first && !OUTPUT_ENABLE_N;
    assign DATA_OUT = st.dout;
    assign DATA_OE  = {(LANES*LANE_W){drive}};

    // ==================================================
    // Checks
    sequence s_qual_write;
        !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && selected && !WRITE_N;
    endsequence

    // Deselect taken on a qualified edge, then one more qualified edge
    sequence s_qual_desel;
        !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && !selected;
    endsequence

    sequence s_desel_then_edge;
        s_qual_desel ##1 !CLOCK_QUALIFY_N;
    endsequence

    // Command capture on qualified edges, hold on unqualified ones, lane and driver gating

    chk_write_taken: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_qual_write |=> st.op1 == SSIC_WRITE)
        else $error("qualified write not taken");
    chk_read_taken: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && selected && WRITE_N |=> st.op1 == SSIC_READ)
        else $error("high strobe started a write");
    chk_freeze_all: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLOCK_QUALIFY_N |=> st == $past(st))
        else $error("state moved while clock unqualified");
    chk_desel_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && !selected |=> st.op1 == SSIC_IDLE)
        else $error("deselect did not idle");
    chk_load_addr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && selected |=> st.addr1 == $past(ADDR))
        else $error("address not loaded");
    chk_burst_step: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && ADVANCE_OR_LOAD && adv_ok |=> st.count == $past(next_count))
        else $error("burst counter not advanced");
    chk_no_lanes: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        st.lanes1 == LANES_OFF |-> lane_wr == '0)
        else $error("write with no lanes touched array");
    chk_oe_write: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        st.op2 != SSIC_READ || st.first |-> DATA_OE == '0)
        else $error("outputs driven when they must be off");
    // An advance steps the counter when a burst is open and never takes a fresh start address
    chk_adv_keep_base: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && ADVANCE_OR_LOAD |=> st.base == $past(st.base))
        else $error("advance reloaded the start address");
    // Every lane write follows its captured select, parity bit included
    chk_lane_gate: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CLOCK_QUALIFY_N && st.op1 == SSIC_WRITE |-> lane_wr == ~st.lanes1)
        else $error("lane write does not follow its select");
    // The data phase of a deselect keeps the drivers off, whatever the enable
    chk_desel_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_desel_then_edge |=> DATA_OE == '0)
        else $error("outputs driven after a deselect");
endmodule // ssic_top

// >>> test/ssic_ctrl_model.sv
// Controller model: drives the SRAM pins, one command per clock.
// Assumes the bench clock; pins move 1 ns after each rising edge.
`timescale 1ns/1ns
module ssic_ctrl_model
    import ssic_pkg::*;
(
    input  wire logic                   clk,    // Bench clock
    output logic [ADDR_W-1:0]           addr,   // Word address
    output logic [LANES-1:0]            lane_n, // Lane selects, low
    output logic                        wr_n,   // Write strobe, low
    output logic                        adv,    // 1 advance, 0 load
    output logic                        qual_n, // Clock qualify, low
    output logic [2:0]                  cs,     // Select 1, 2, 3 raw levels
    output logic [LANES*LANE_W-1:0]     data    // Write data bus
);
    logic [LANES*LANE_W-1:0] pend   = '0;   // Write data owed next edge
    logic                    pend_v = 1'h0; // A write is owed
    initial {addr, lane_n, wr_n, adv, qual_n, cs, data} = '1;
    // One command; its write data follows one qualified edge later
    task automatic cyc(input logic q, input logic [2:0] s, input logic ad, input logic we,
                       input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic [LANES*LANE_W-1:0] d);
        {qual_n, cs, adv, wr_n, addr, lane_n} = {q, s, ad, we, a, ln}; // Strobe low only to write
        data = pend_v ? pend : ~data;  // Idle bus never holds its last value
        if (!q)
            {pend_v, pend} = {!we, d};
        @(posedge clk);
        #1;
    endtask
endmodule // ssic_ctrl_model

// >>> test/tb_sync_sram_input_control.sv
// Bench for the SRAM input control: a row table of pin commands, then a
// mid-run reset with interleaved bursts. Assumes the controller model.
`timescale 1ns/1ns
module tb_sync_sram_input_control;
    import ssic_pkg::*;
    // ==================================================
    // Signals and rows
    localparam int         DW = LANES*LANE_W;
    localparam logic [2:0] ON = 3'h2;  // Select 1 low, 2 high, 3 low
    typedef struct packed {  // Pins, then expected OE and data
        logic q; logic [2:0] s; logic ad; logic we; logic [ADDR_W-1:0] a; logic [LANES-1:0] ln;
        logic [DW-1:0] d; logic oen; logic chk; logic eoe; logic [DW-1:0] eo; } ssic_row_t;
    logic              CLOCK, SYS_RST, BURST_INTERLEAVE, OUTPUT_ENABLE_N, wr_n, adv, qual_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_n;
    logic [2:0]        cs;
    logic [DW-1:0]     din, dout, doe;
    int                failures = 0, tests_run = 0;
    ssic_row_t         rows [20];
    ssic_ctrl_model u_ssic_ctrl_model (.clk(CLOCK), .addr(addr), .lane_n(lane_n), .wr_n(wr_n),
        .adv(adv), .qual_n(qual_n), .cs(cs), .data(din));
    ssic_top u_ssic_top (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(addr), .BYTE_LANE_WRITE_N(lane_n),
        .WRITE_N(wr_n), .ADVANCE_OR_LOAD(adv), .CLOCK_QUALIFY_N(qual_n), .CHIP_SELECT_1_N(cs[2]),
        .CHIP_SELECT_2(cs[1]), .CHIP_SELECT_3_N(cs[0]), .BURST_INTERLEAVE(BURST_INTERLEAVE),
        .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe));
    initial
    begin
        CLOCK = 1'h0;
        forever #5 CLOCK = ~CLOCK;
    end
    // Watchdog: about 1000 cycles, the run needs under 50
    initial
    begin
        #10000;
        failures++;
        wrap_up();
    end
    task automatic check(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        tests_run++;
        if (seen !== exp)
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        if (seen !== exp)
            failures++;
    endtask
    task automatic wrap_up();
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One command, then the outputs left by the edge it met
    task automatic run(input ssic_row_t r);
        OUTPUT_ENABLE_N = r.oen;
        u_ssic_ctrl_model.cyc(r.q, r.s, r.ad, r.we, r.a, r.ln, r.d);
        check("oe", doe, {DW{r.eoe}});
        if (r.chk)
            check("dout", dout, r.eo);
    endtask
    // ==================================================
    // Main sequence
    initial
    begin
        SYS_RST          = 1'h1;
        BURST_INTERLEAVE = 1'h0;
        OUTPUT_ENABLE_N  = 1'h0;
        // Writes 08..0a by burst, lane b/d rewrite, empty-lane write, then reads
        // Read data is registered at the edge after the load and shows from then on
        rows = '{
        '{'0,ON,'0,'0,6'h08,4'h0,36'h0,'0,'0,'0,'0},
        '{'0,ON,'1,'0,6'h3f,4'h0,36'h123456789,'0,'0,'0,'0},
        '{'0,ON,'1,'0,6'h3f,4'h0,36'h9abcdef01,'0,'0,'0,'0},
        '{'0,ON,'0,'0,6'h08,4'h5,'1,'0,'0,'0,'0},
        '{'0,ON,'0,'0,6'h09,4'hf,36'h0f0f0f0f0,'0,'0,'0,'0},
        '{'0,ON,'0,'1,6'h08,4'h0,'0,'0,'0,'0,'0},
        '{'0,ON,'1,'1,6'h3f,4'h0,'0,'0,'1,'1,36'hff803fe00},
        '{'0,ON,'1,'1,6'h3f,4'h0,'0,'0,'1,'1,36'h123456789},
        '{'1,ON,'0,'0,6'h0a,4'h0,'1,'0,'1,'1,36'h123456789},
        '{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'1,36'h9abcdef01},
        '{'0,3'h0,'0,'1,6'h00,4'h0,'0,'0,'1,'0,36'h9abcdef01},
        '{'0,ON,'0,'1,6'h0a,4'h0,'0,'0,'0,'0,'0},
        '{'0,3'h3,'0,'1,6'h00,4'h0,'0,'0,'1,'1,36'h9abcdef01},
        '{'0,ON,'0,'1,6'h08,4'h0,'0,'0,'1,'0,36'h9abcdef01},
        '{'0,3'h6,'0,'1,6'h00,4'h0,'0,'1,'1,'0,36'hff803fe00},
        '{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'0,36'hff803fe00},
        '{'0,ON,'0,'0,6'h0c,4'h0,36'h3c3c3c3c3,'0,'0,'0,'0},
        '{'0,ON,'0,'1,6'h0c,4'h0,'0,'0,'0,'0,'0},
        '{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'1,36'h3c3c3c3c3},
        '{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'0,36'h3c3c3c3c3}};
        repeat (6) @(posedge CLOCK);
        #1;
        SYS_RST = 1'h0;
        foreach (rows[i])
            run(rows[i]);
        // Mid-run reset clears outputs; the strap is caught while it is held
        SYS_RST          = 1'h1;
        BURST_INTERLEAVE = 1'h1;
        repeat (2) @(posedge CLOCK);
        #1;
        check("dout_rst", dout, '0);
        check("oe_rst", doe, '0);
        SYS_RST = 1'h0;
        run('{'0,ON,'0,'0,6'h11,4'h0,36'h3c3c3c3c3,'0,'0,'0,'0});
        run('{'0,ON,'1,'0,6'h00,4'h0,36'h876543210,'0,'0,'0,'0});  // Step 01 xor 01 lands on 10
        run('{'0,ON,'0,'1,6'h10,4'h0,'0,'0,'0,'0,'0});
        run('{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'1,36'h876543210});
        run('{'0,3'h6,'0,'1,6'h00,4'h0,'0,'0,'1,'0,36'h876543210});
        wrap_up();
    end
endmodule // tb_sync_sram_input_control
